// ==== pkg/sso_params.svh ====
// Purpose: constants of the sync sleep options and status bank
// Assumes: included by bare name; definitions only
// Notes:   bit positions, reset values, accepted ranges
`ifndef SSO_PARAMS_SVH
`define SSO_PARAMS_SVH

// option flag bit positions
`define SSO_OPT_COORD_FORCE  0
`define SSO_OPT_COORD_NEVER  1
`define SSO_OPT_API_STATUS   2
`define SSO_OPT_NO_EARLY     3
`define SSO_OPT_TYPE_EQUAL   4
`define SSO_OPT_NO_RAPID     5
`define SSO_OPT_FULL_WAKE    8
`define SSO_OPT_DEFINED_MASK 16'h013F
`define SSO_OPT_RESET        16'h0000

// status word bit positions
`define SSO_STAT_NET_AWAKE    0
`define SSO_STAT_COORD        1
`define SSO_STAT_EVER_SYNCED  2
`define SSO_STAT_SYNC_THIS    3
`define SSO_STAT_SETTINGS_CHG 4
`define SSO_STAT_NOMINATE_REQ 5
`define SSO_STAT_DEPLOY       6

// configured period (x 10 ms) and wake time (x 1 ms)
`define SSO_PER_RESET        32'h000000C8
`define SSO_PER_MIN          32'h00000001
`define SSO_PER_MAX          32'h0015F900
`define SSO_WAKE_RESET       32'h000007D0
`define SSO_WAKE_MIN         32'h00000001
`define SSO_WAKE_MAX         32'h0036EE80
`define SSO_CNT_MAX          16'hFFFF

`endif

// ==== pkg/sso_pkg.sv ====
// Purpose: types shared by the sync sleep options and status bank
// Assumes: nothing
// Notes:   command selectors stand for the host's text commands
package sso_pkg;
   typedef logic [31:0] sso_word_t;

   typedef enum logic [3:0] {
      SSO_CMD_OPTIONS  = 4'h0,
      SSO_CMD_STATE    = 4'h1,
      SSO_CMD_OP_SLEEP = 4'h2,
      SSO_CMD_OP_WAKE  = 4'h3,
      SSO_CMD_MISSED   = 4'h4,
      SSO_CMD_TALLY    = 4'h5,
      SSO_CMD_PERIOD   = 4'h6,
      SSO_CMD_WAKETIME = 4'h7,
      SSO_CMD_MODE     = 4'h8
   } sso_cmd_t;

   typedef enum logic [3:0] {
      SSO_MODE_AWAKE     = 4'h0,
      SSO_MODE_PIN       = 4'h1,
      SSO_MODE_RSV2      = 4'h2,
      SSO_MODE_RSV3      = 4'h3,
      SSO_MODE_ASYNC     = 4'h4,
      SSO_MODE_ASYNC_PIN = 4'h5,
      SSO_MODE_SCRIPT    = 4'h6,
      SSO_MODE_SUPPORT   = 4'h7,
      SSO_MODE_SYNC      = 4'h8
   } sso_mode_t;
endpackage : sso_pkg

// ==== pkg/sso_cnt_if.sv ====
// Purpose: control and value of one saturating counter
// Assumes: one controller, one counter
// Notes:   load and increment may coincide
`timescale 1ns/100ps
interface sso_cnt_if #(parameter int W = 16);
   logic         load;
   logic [W-1:0] load_val;
   logic         inc;
   logic [W-1:0] count;

   modport ctl (output load, output load_val, output inc, input count);
   modport cnt (input load, input load_val, input inc, output count);
endinterface : sso_cnt_if

// ==== core/sso_sat_counter.sv ====
// Purpose: counter that stops at its all-ones value
// Assumes: load and inc are one-cycle pulses
// Notes:   a load and an increment together give load value plus one
`timescale 1ns/100ps
module sso_sat_counter #(
   parameter int W = 16
) (
   input  wire logic mclk_i,
   input  wire logic rst_n_i,
   sso_cnt_if.cnt    cnt_if
);
   logic [W-1:0] count_reg;
   logic [W-1:0] base;
   logic [W-1:0] count_next;
   logic         at_max;

   // the event is not lost when it meets a load
   assign base       = cnt_if.load ? cnt_if.load_val : count_reg;
   assign at_max     = &base;
   assign count_next = (cnt_if.inc && !at_max) ? base + {{(W-1){1'b0}}, 1'b1} : base;
   assign cnt_if.count = count_reg;

   // count register
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         count_reg <= '0;
      else
         count_reg <= count_next;
   end
endmodule : sso_sat_counter

// ==== core/sso_top.sv ====
// Purpose: options, status and timing readouts of synchronized cyclic sleep
// Assumes: host commands arrive decoded on the cmd port, one per cycle at most
// Notes:   answers come one cycle after the command; cycle events are pulses
//
// Notes on behaviour
// - option bit 0 on a sleep-capable node forces the coordinator role.
// - option bit 1 forbids the coordinator role in all conditions.
// - option bit 2 enables sleep status messages to the host.
// - option bit 3 disables early wake after missed syncs.
// - option bit 4 drops device-type seniority in coordinator selection.
// - option bit 5 disables rapid-sync deployment mode as coordinator.
// - option bit 8 in asynchronous sleep keeps awake for full wake time.
// - diagnostics are meaningful in sync support or sync cyclic sleep modes.
// - status bit 0 shows the network awake and receiving.
// - status bit 1 shows this node acting as sleep coordinator.
// - status bit 2 sets on first valid sync and stays set.
// - status bit 3 shows a sync received this wake cycle.
// - settings change sets bit 4, nominates and syncs at next wake.
// - status bit 5 shows a requested self-nomination by button or command.
// - status bit 6 shows deployment mode; other bits are ignored.
// - operating sleep is the network value, else configured period, 10 ms units.
// - operating wake is the network value, else configured wake time, 1 ms.
// - missed-sync count gives sleep and wake starts since the last sync message.
// - missed-sleep-sync tally counts syncless sleeps, saturates, clears on zero.
// - configured sleep period is per-cycle sleep time in 10 ms units.
// - configured wake time is per-cycle awake time in 1 ms units.
// - synchronized nodes all run the network's wake and sleep timing.
`timescale 1ns/100ps
`include "sso_params.svh"
module sso_top (
   input  wire logic              mclk_i,
   input  wire logic              rst_n_i,
   input  wire logic              cmd_valid_i,
   input  wire logic              cmd_write_i,
   input  wire sso_pkg::sso_cmd_t cmd_sel_i,
   input  wire sso_pkg::sso_word_t cmd_wdata_i,
   output logic                   rsp_valid_o,
   output sso_pkg::sso_word_t     rsp_data_o,
   output logic                   rsp_err_o,
   input  wire logic              net_awake_i,
   input  wire logic              coord_elect_i,
   input  wire logic              deploy_mode_i,
   input  wire logic              sync_rx_i,
   input  wire sso_pkg::sso_word_t sync_sleep_i,
   input  wire sso_pkg::sso_word_t sync_wake_i,
   input  wire logic              wake_start_i,
   input  wire logic              sleep_start_i,
   input  wire logic              nominate_req_i,
   output logic                   coord_role_o,
   output logic                   api_status_en_o,
   output logic                   early_wake_en_o,
   output logic                   seniority_en_o,
   output logic                   rapid_sync_en_o,
   output logic                   always_full_wake_o,
   output logic                   diag_valid_o,
   output logic                   nominate_sync_o,
   output sso_pkg::sso_word_t     sleep_interval_o,
   output sso_pkg::sso_word_t     wake_interval_o
);
   import sso_pkg::*;

   logic [15:0] opt_reg;
   sso_word_t   period_reg;
   sso_word_t   waketime_reg;
   sso_mode_t   mode_reg;
   logic        synced_reg;
   logic        sync_this_reg;
   logic        chg_reg;
   logic        nom_reg;
   sso_word_t   net_sleep_reg;
   sso_word_t   net_wake_reg;
   sso_word_t   op_sleep_reg;
   sso_word_t   op_wake_reg;
   sso_word_t   rdata;
   logic        wr_err;
   logic        rd_err;

   sso_cnt_if #(.W(16)) missed_if ();
   sso_cnt_if #(.W(16)) tally_if ();

   // write strobes per command
   wire wr       = cmd_valid_i && cmd_write_i;
   wire wr_opt   = wr && (cmd_sel_i == SSO_CMD_OPTIONS);
   wire wr_tally = wr && (cmd_sel_i == SSO_CMD_TALLY);
   wire wr_per   = wr && (cmd_sel_i == SSO_CMD_PERIOD);
   wire wr_wake  = wr && (cmd_sel_i == SSO_CMD_WAKETIME);
   wire wr_mode  = wr && (cmd_sel_i == SSO_CMD_MODE);

   // option value checks; a refused write keeps the old flags
   // refuse bad options
   wire opt_undef   = |(cmd_wdata_i & ~{16'h0000, `SSO_OPT_DEFINED_MASK});
   wire opt_both    = cmd_wdata_i[`SSO_OPT_COORD_FORCE] && cmd_wdata_i[`SSO_OPT_COORD_NEVER];
   wire opt_ok      = !opt_undef && !opt_both;
   wire per_ok      = (cmd_wdata_i >= `SSO_PER_MIN) && (cmd_wdata_i <= `SSO_PER_MAX);
   wire wake_ok     = (cmd_wdata_i >= `SSO_WAKE_MIN) && (cmd_wdata_i <= `SSO_WAKE_MAX);
   wire mode_ok     = cmd_wdata_i <= 32'h00000008;
   wire tally_ok    = cmd_wdata_i[31:16] == 16'h0000;
   wire opt_take    = wr_opt && opt_ok;
   wire per_take    = wr_per && per_ok;
   wire wake_take   = wr_wake && wake_ok;
   wire mode_take   = wr_mode && mode_ok;
   wire settings_wr = opt_take || per_take || wake_take || mode_take;

   // mode classes; sync-capable modes are the ones the diagnostics serve
   // diagnostics valid in sync modes
   wire sync_mode  = (mode_reg == SSO_MODE_SUPPORT) || (mode_reg == SSO_MODE_SYNC);
   wire async_mode = (mode_reg == SSO_MODE_ASYNC) || (mode_reg == SSO_MODE_ASYNC_PIN);
   assign diag_valid_o = sync_mode;

   // coordinator role: never wins over forced, forced wins over election
   // forced coordinator
   assign coord_role_o = sync_mode && !opt_reg[`SSO_OPT_COORD_NEVER]
                         && (opt_reg[`SSO_OPT_COORD_FORCE] || coord_elect_i);
   assign api_status_en_o  = opt_reg[`SSO_OPT_API_STATUS];
   assign early_wake_en_o  = !opt_reg[`SSO_OPT_NO_EARLY];
   assign seniority_en_o   = !opt_reg[`SSO_OPT_TYPE_EQUAL];
   assign rapid_sync_en_o  = coord_role_o && !opt_reg[`SSO_OPT_NO_RAPID];
   assign always_full_wake_o = async_mode && opt_reg[`SSO_OPT_FULL_WAKE];
   assign nominate_sync_o  = chg_reg && wake_start_i;

   // configuration registers
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         opt_reg      <= `SSO_OPT_RESET;
         period_reg   <= `SSO_PER_RESET;
         waketime_reg <= `SSO_WAKE_RESET;
         mode_reg     <= SSO_MODE_AWAKE;
      end
      else
      begin
         if (opt_take)
            opt_reg <= cmd_wdata_i[15:0];
         if (per_take)
            period_reg <= cmd_wdata_i;
         if (wake_take)
            waketime_reg <= cmd_wdata_i;
         if (mode_take)
            mode_reg <= sso_mode_t'(cmd_wdata_i[3:0]);
      end
   end

   // sync tracking; a new sync always beats the wake-cycle clear
   // sticky ever-synced
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         synced_reg    <= 1'b0;
         sync_this_reg <= 1'b0;
         net_sleep_reg <= 32'h00000000;
         net_wake_reg  <= 32'h00000000;
      end
      else
      begin
         synced_reg    <= synced_reg || sync_rx_i;
         sync_this_reg <= sync_rx_i || (sync_this_reg && !wake_start_i);
         if (sync_rx_i)
         begin
            net_sleep_reg <= sync_sleep_i;
            net_wake_reg  <= sync_wake_i;
         end
      end
   end

   // pending flags; a fresh request beats the clear in the same cycle
   // settings change flag
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         chg_reg <= 1'b0;
         nom_reg <= 1'b0;
      end
      else
      begin
         chg_reg <= settings_wr || (chg_reg && !wake_start_i);
         nom_reg <= nominate_req_i || (nom_reg && !coord_role_o);
      end
   end

   // operating timing, held in flops so the readout is stable
   // sleep fallback to period
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         op_sleep_reg <= `SSO_PER_RESET;
         op_wake_reg  <= `SSO_WAKE_RESET;
      end
      else
      begin
         op_sleep_reg <= synced_reg ? net_sleep_reg : period_reg;
         op_wake_reg  <= synced_reg ? net_wake_reg : waketime_reg;
      end
   end
   assign sleep_interval_o = op_sleep_reg;
   assign wake_interval_o  = op_wake_reg;

   // missed sync: cleared by a sync, counts every sleep or wake start
   // cycles since sync
   assign missed_if.load     = sync_rx_i;
   assign missed_if.load_val = 16'h0000;
   assign missed_if.inc      = sleep_start_i || wake_start_i;

   // tally: sleep starts after a wake with no sync; host may reload it
   // saturating syncless tally
   assign tally_if.load     = wr_tally && tally_ok;
   assign tally_if.load_val = cmd_wdata_i[15:0];
   assign tally_if.inc      = sleep_start_i && !sync_this_reg;

   sso_sat_counter #(.W(16)) u_missed (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .cnt_if  (missed_if.cnt)
   );

   sso_sat_counter #(.W(16)) u_tally (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .cnt_if  (tally_if.cnt)
   );

   // read mux; status reserved bits read zero
   // network awake bit
   wire [15:0] state_word = {9'h000, deploy_mode_i, nom_reg, chg_reg, sync_this_reg,
                             synced_reg, coord_role_o, net_awake_i};
   always_comb
   begin
      rdata  = 32'h00000000;
      rd_err = 1'b0;
      case (cmd_sel_i)
         SSO_CMD_OPTIONS:  rdata = {16'h0000, opt_reg};
         SSO_CMD_STATE:    rdata = {16'h0000, state_word};
         SSO_CMD_OP_SLEEP: rdata = op_sleep_reg;
         SSO_CMD_OP_WAKE:  rdata = op_wake_reg;
         SSO_CMD_MISSED:   rdata = {16'h0000, missed_if.count};
         SSO_CMD_TALLY:    rdata = {16'h0000, tally_if.count};
         SSO_CMD_PERIOD:   rdata = period_reg;
         SSO_CMD_WAKETIME: rdata = waketime_reg;
         SSO_CMD_MODE:     rdata = {28'h0000000, mode_reg};
         default:          rd_err = 1'b1;
      endcase
   end

   // write refusal: read-only targets, out-of-range values
   assign wr_err = (wr_opt && !opt_ok) || (wr_per && !per_ok) || (wr_wake && !wake_ok)
                   || (wr_mode && !mode_ok) || (wr_tally && !tally_ok)
                   || (cmd_sel_i == SSO_CMD_STATE) || (cmd_sel_i == SSO_CMD_OP_SLEEP)
                   || (cmd_sel_i == SSO_CMD_OP_WAKE) || (cmd_sel_i == SSO_CMD_MISSED)
                   || rd_err;

   // answer one cycle after each command
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rsp_valid_o <= 1'b0;
         rsp_data_o  <= 32'h00000000;
         rsp_err_o   <= 1'b0;
      end
      else
      begin
         rsp_valid_o <= cmd_valid_i;
         rsp_data_o  <= (cmd_valid_i && !cmd_write_i) ? rdata : 32'h00000000;
         rsp_err_o   <= cmd_valid_i && (cmd_write_i ? wr_err : rd_err);
      end
   end

   // checks on the logic above
   AST_NEVER_COORD: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      opt_reg[`SSO_OPT_COORD_NEVER] |-> !coord_role_o)
      else $error("coordinator role taken while forbidden");

   AST_FORCE_COORD: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (opt_reg[`SSO_OPT_COORD_FORCE] && sync_mode) |-> coord_role_o)
      else $error("forced coordinator role missing");

   AST_BAD_OPT_KEEP: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (wr_opt && !opt_ok) |=> (rsp_valid_o && rsp_err_o && $stable(opt_reg)))
      else $error("bad option write not refused");

   AST_SYNC_STICKY: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (sync_rx_i || synced_reg) |=> synced_reg)
      else $error("ever-synced flag dropped");

   AST_SYNC_WAKE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (sync_rx_i && wake_start_i) |=> sync_this_reg)
      else $error("sync lost against wake clear");

   AST_CHG_NOM: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (settings_wr || (chg_reg && !wake_start_i)) |=> chg_reg)
      else $error("settings change flag not held");

   AST_CHG_CLR: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (chg_reg && wake_start_i && !settings_wr) |=> !chg_reg)
      else $error("settings change flag not cleared at wake");

   AST_OS_FALLBACK: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (!synced_reg ##1 !synced_reg) |-> sleep_interval_o == $past(period_reg))
      else $error("operating sleep not the configured period");

   AST_OW_NET: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (synced_reg && !sync_rx_i) |=> ##1 wake_interval_o == $past(net_wake_reg, 2))
      else $error("operating wake not the network value");

   AST_MISSED_CLR: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (sync_rx_i && !wake_start_i && !sleep_start_i) |=> missed_if.count == 16'h0000)
      else $error("missed sync count not cleared");

   AST_TALLY_SAT: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (tally_if.count == `SSO_CNT_MAX && !wr_tally) |=> tally_if.count == `SSO_CNT_MAX)
      else $error("tally passed its maximum");
endmodule : sso_top

// ==== verification/sso_host_model.sv ====
// Purpose: host side that issues decoded text commands to the bank
// Assumes: one command in flight; the answer is registered at the taking edge
// Notes:   released write data shows the inverse of the last value
`timescale 1ns/100ps
module sso_host_model (
   input  wire logic               mclk_i,
   output logic                    cmd_valid_o,
   output logic                    cmd_write_o,
   output sso_pkg::sso_cmd_t       cmd_sel_o,
   output sso_pkg::sso_word_t      cmd_wdata_o,
   input  wire logic               rsp_valid_i,
   input  wire sso_pkg::sso_word_t rsp_data_i,
   input  wire logic               rsp_err_i
);
   import sso_pkg::*;

   // idle command lines from time zero
   initial
   begin
      cmd_valid_o = 1'b0;
      cmd_write_o = 1'b0;
      cmd_sel_o   = SSO_CMD_OPTIONS;
      cmd_wdata_o = 32'h00000000;
   end

   // option values legal unless the caller means a refusal
   // raise after an edge, hold through the taking edge, then read the answer
   task xfer(input logic wr, input sso_cmd_t sel, input sso_word_t wd,
             output sso_word_t rd, output logic err, output logic ok);
      @(posedge mclk_i);
      #1;
      cmd_valid_o = 1'b1;
      cmd_write_o = wr;
      cmd_sel_o   = sel;
      cmd_wdata_o = wd;
      @(posedge mclk_i);
      #1;
      ok          = rsp_valid_i;
      rd          = rsp_data_i;
      err         = rsp_err_i;
      cmd_valid_o = 1'b0;
      cmd_wdata_o = ~wd; // no stale value on a released bus
   endtask : xfer
endmodule : sso_host_model

// ==== verification/test_sso_top.sv ====
// Purpose: self-checking bench of the sync sleep options and status bank
// Assumes: host model drives commands; bench drives network events
// Notes:   all inputs change 1 ns after the rising edge
`timescale 1ns/100ps
`include "sso_params.svh"
module test_sso_top;
   import sso_pkg::*;
   logic      mclk, rst_n, cmd_valid, cmd_write, rsp_valid, rsp_err, ns_seen;
   logic      net_awake, coord_elect, deploy, sync_rx, wake_start, sleep_start, nom_req;
   logic      coord_role, api_en, early_en, senior_en, rapid_en, full_wake, diag_valid;
   logic      nom_sync;
   sso_cmd_t  cmd_sel;
   sso_word_t cmd_wdata, rsp_data, sync_sleep, sync_wake, sleep_iv, wake_iv;
   int        bad_count, n_tests, cycles;

   sso_top uut (.mclk_i(mclk), .rst_n_i(rst_n), .cmd_valid_i(cmd_valid),
      .cmd_write_i(cmd_write), .cmd_sel_i(cmd_sel), .cmd_wdata_i(cmd_wdata),
      .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .rsp_err_o(rsp_err),
      .net_awake_i(net_awake), .coord_elect_i(coord_elect), .deploy_mode_i(deploy),
      .sync_rx_i(sync_rx), .sync_sleep_i(sync_sleep), .sync_wake_i(sync_wake),
      .wake_start_i(wake_start), .sleep_start_i(sleep_start), .nominate_req_i(nom_req),
      .coord_role_o(coord_role), .api_status_en_o(api_en), .early_wake_en_o(early_en),
      .seniority_en_o(senior_en), .rapid_sync_en_o(rapid_en),
      .always_full_wake_o(full_wake), .diag_valid_o(diag_valid),
      .nominate_sync_o(nom_sync), .sleep_interval_o(sleep_iv), .wake_interval_o(wake_iv));

   sso_host_model host (.mclk_i(mclk), .cmd_valid_o(cmd_valid), .cmd_write_o(cmd_write),
      .cmd_sel_o(cmd_sel), .cmd_wdata_o(cmd_wdata), .rsp_valid_i(rsp_valid),
      .rsp_data_i(rsp_data), .rsp_err_i(rsp_err));

   // 20 MHz clock
   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // hang guard, well above the fewer than two hundred cycles the run needs
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         bad_count++;
         report_and_stop();
      end
   end

   function sso_word_t b1(input logic x);
      return {31'h0, x};
   endfunction : b1

   task report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : report_and_stop

   task chk(input sso_word_t seen, input sso_word_t exp);
      n_tests++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // command wrappers; wr and rchk require the answer to come with the one-cycle pulse, stat_bit does not check it
   task wr(input sso_cmd_t s, input sso_word_t v, input logic ee);
      sso_word_t d;
      logic      e, ok;
      host.xfer(1'b1, s, v, d, e, ok);
      chk(b1(ok), 32'h1);
      chk(b1(e), b1(ee));
   endtask : wr

   task rchk(input sso_cmd_t s, input sso_word_t exp);
      sso_word_t d;
      logic      e, ok;
      host.xfer(1'b0, s, 32'h0, d, e, ok);
      chk(b1(ok), 32'h1);
      chk(b1(e), 32'h0);
      chk(d, exp);
   endtask : rchk

   task stat_bit(input int n, input logic exp);
      sso_word_t d;
      logic      e, ok;
      host.xfer(1'b0, SSO_CMD_STATE, 32'h0, d, e, ok);
      chk(b1(d[n]), b1(exp));
   endtask : stat_bit

   // one-cycle event pulse: 0 sync, 1 wake start, 2 sleep start, 3 nominate
   task ev(input int k);
      @(posedge mclk);
      #1;
      case (k)
         0: sync_rx = 1'b1;
         1: wake_start = 1'b1;
         2: sleep_start = 1'b1;
         default: nom_req = 1'b1;
      endcase
      #1 ns_seen = nom_sync;
      @(posedge mclk);
      #1;
      {sync_rx, wake_start, sleep_start, nom_req} = 4'h0;
   endtask : ev

   task t_reset();
      sso_word_t d;
      logic      e, ok;
      chk(b1(early_en), 32'h1);
      chk(b1(senior_en), 32'h1);
      chk(b1(coord_role), 32'h0);
      chk(sleep_iv, `SSO_PER_RESET);
      chk(wake_iv, `SSO_WAKE_RESET);
      rchk(SSO_CMD_OPTIONS, `SSO_OPT_RESET);
      rchk(SSO_CMD_PERIOD, `SSO_PER_RESET);
      rchk(SSO_CMD_WAKETIME, `SSO_WAKE_RESET);
      rchk(SSO_CMD_OP_WAKE, `SSO_WAKE_RESET);
      rchk(SSO_CMD_TALLY, 32'h0);
      host.xfer(1'b0, sso_cmd_t'(4'h9), 32'h0, d, e, ok);
      chk(b1(e), 32'h1);
   endtask : t_reset

   task t_options();
      wr(SSO_CMD_OPTIONS, 32'h4, 1'b0);
      chk(b1(api_en), 32'h1);
      wr(SSO_CMD_OPTIONS, 32'h8, 1'b0);
      chk(b1(early_en), 32'h0);
      wr(SSO_CMD_OPTIONS, 32'h10, 1'b0);
      chk(b1(senior_en), 32'h0);
      wr(SSO_CMD_OPTIONS, 32'h3, 1'b1);
      rchk(SSO_CMD_OPTIONS, 32'h10);
      wr(SSO_CMD_OPTIONS, 32'h40, 1'b1);
      wr(SSO_CMD_OPTIONS, 32'h13E, 1'b0);
      rchk(SSO_CMD_OPTIONS, 32'h13E);
      wr(SSO_CMD_STATE, 32'h0, 1'b1);
      wr(SSO_CMD_OP_SLEEP, 32'h0, 1'b1);
      wr(SSO_CMD_OP_WAKE, 32'h0, 1'b1);
      wr(SSO_CMD_MISSED, 32'h0, 1'b1);
      wr(sso_cmd_t'(4'hF), 32'h0, 1'b1);
      wr(SSO_CMD_OPTIONS, 32'h0, 1'b0);
   endtask : t_options

   task t_coord();
      wr(SSO_CMD_MODE, 32'h8, 1'b0);
      wr(SSO_CMD_OPTIONS, 32'h1, 1'b0);
      chk(b1(coord_role), 32'h1);
      chk(b1(rapid_en), 32'h1);
      stat_bit(1, 1'b1);
      wr(SSO_CMD_OPTIONS, 32'h21, 1'b0);
      chk(b1(rapid_en), 32'h0);
      wr(SSO_CMD_OPTIONS, 32'h2, 1'b0);
      coord_elect = 1'b1;
      #1 chk(b1(coord_role), 32'h0);
      wr(SSO_CMD_OPTIONS, 32'h0, 1'b0);
      chk(b1(coord_role), 32'h1);
      coord_elect = 1'b0;
      #1 stat_bit(1, 1'b0);
   endtask : t_coord

   task t_modes();
      wr(SSO_CMD_OPTIONS, 32'h100, 1'b0);
      for (int m = 0; m < 9; m++)
      begin
         wr(SSO_CMD_MODE, m, 1'b0);
         chk(b1(full_wake), b1(m == 4 || m == 5));
         chk(b1(diag_valid), b1(m >= 7));
      end
      wr(SSO_CMD_MODE, 32'h9, 1'b1);
      rchk(SSO_CMD_MODE, 32'h8);
      wr(SSO_CMD_OPTIONS, 32'h0, 1'b0);
   endtask : t_modes

   task t_settings();
      ev(1);
      stat_bit(4, 1'b0);
      wr(SSO_CMD_PERIOD, 32'h10, 1'b0);
      stat_bit(4, 1'b1);
      chk(sleep_iv, 32'h10);
      wr(SSO_CMD_WAKETIME, `SSO_WAKE_MAX, 1'b0);
      rchk(SSO_CMD_OP_WAKE, `SSO_WAKE_MAX);
      ev(1);
      chk(b1(ns_seen), 32'h1);
      ev(1);
      chk(b1(ns_seen), 32'h0);
      wr(SSO_CMD_PERIOD, 32'h0, 1'b1);
      wr(SSO_CMD_PERIOD, `SSO_PER_MAX + 32'h1, 1'b1);
      wr(SSO_CMD_WAKETIME, 32'h0, 1'b1);
      wr(SSO_CMD_WAKETIME, `SSO_WAKE_MAX + 32'h1, 1'b1);
      stat_bit(4, 1'b0);
      rchk(SSO_CMD_OP_SLEEP, 32'h10);
   endtask : t_settings

   task t_nominate();
      ev(3);
      stat_bit(5, 1'b1);
      coord_elect = 1'b1;
      #1 stat_bit(5, 1'b0);
      coord_elect = 1'b0;
   endtask : t_nominate

   task t_tally();
      wr(SSO_CMD_TALLY, 32'hFFFE, 1'b0);
      ev(2);
      rchk(SSO_CMD_TALLY, 32'hFFFF);
      ev(2);
      rchk(SSO_CMD_TALLY, 32'hFFFF);
      wr(SSO_CMD_TALLY, 32'h0, 1'b0);
      ev(2);
      rchk(SSO_CMD_TALLY, 32'h1);
      wr(SSO_CMD_TALLY, 32'h10000, 1'b1);
   endtask : t_tally

   task t_sync();
      net_awake = 1'b1;
      deploy = 1'b1;
      stat_bit(0, 1'b1);
      stat_bit(6, 1'b1);
      stat_bit(2, 1'b0);
      sync_sleep = 32'h1234;
      sync_wake = 32'h56;
      ev(0);
      stat_bit(2, 1'b1);
      stat_bit(3, 1'b1);
      rchk(SSO_CMD_MISSED, 32'h0);
      chk(sleep_iv, 32'h1234);
      chk(wake_iv, 32'h56);
      rchk(SSO_CMD_OP_SLEEP, 32'h1234);
      ev(2);
      rchk(SSO_CMD_TALLY, 32'h1);
      ev(1);
      stat_bit(3, 1'b0);
      stat_bit(2, 1'b1);
      rchk(SSO_CMD_MISSED, 32'h2);
      net_awake = 1'b0;
      deploy = 1'b0;
      stat_bit(0, 1'b0);
      stat_bit(6, 1'b0);
   endtask : t_sync

   // reset, then the scenarios in an order that keeps each one's start known
   initial
   begin
      {bad_count, n_tests, cycles} = '0;
      {net_awake, coord_elect, deploy, sync_rx, wake_start, sleep_start, nom_req} = '0;
      sync_sleep = 32'h0;
      sync_wake = 32'h0;
      rst_n = 1'b0;
      repeat (8) @(posedge mclk);
      #1 rst_n = 1'b1;
      t_reset();
      t_options();
      t_coord();
      t_modes();
      t_settings();
      t_nominate();
      t_tally();
      t_sync();
      report_and_stop();
   end
endmodule : test_sso_top
